// [hw/bridge_gate_control_logic.sv]
// Gate command logic for four half-bridges in half-bridge, H-bridge and solenoid modes.
//
// Overview of operation
// - Mode selector 00b runs the four gate drivers as independent half-bridges.
// - State 00b floats, 01b low side, 10b high side, 11b PWM mapping.
// - Input selector 00b..11b picks control input one to four; sharing allowed.
// - PWM drives high side (0) or low side (1); freewheel 0 complements, 1 low.
// - Without register port: high-side PWM, active freewheel, input n feeds bridge n.
// - Half-bridges 1/2 and 3/4 form the two H-bridge pairs.
// - Selector 01b is speed/direction, 10b is four-state PWM.
// - Without register port, mode pin level 2 and 3 pick those modes.
// - Enable low: both low sides on (side 0) or both high sides (side 1).
// - Enable high: direction 1 forward, direction 0 reverse.
// - Four-state: 0/0 coast, 1/0 forward, 0/1 reverse.
// - Four-state 1/1: active freewheel on the side the freewheel bit picks.
// - A pair's float bit forces all its four gates low.
// - Freewheel side resets to low side; software may set high side.
// - Without register port, H-bridge modes always freewheel on low side.
// - Source select bits take enable and direction from register bits.
// - Selector 11b or mode pin level 4 selects split solenoid mode.
// - Solenoid: primary high side follows direction value.
// - Solenoid: secondary low side follows enable value.
// - Solenoid: primary low side and secondary high side stay off.
`timescale 1ns/10ps
module bridge_gate_control_logic
  import gate_pkg::*;
#(
  parameter bit HAS_REG_PORT = 1'b1
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control inputs from the controller.
  input wire logic pair1_enable_input,
  input wire logic pair1_direction_input,
  input wire logic pair2_enable_input,
  input wire logic pair2_direction_input,
  // Multi-level mode pin, used only without the register port.
  input wire logic [1:0] mode_pin_level,
  // Settings write strobe and settings.
  input wire logic config_write,
  input wire logic [1:0] bridge_config_sel,
  input wire hb_cfg_t [NUM_HB-1:0] hb_cfg_in,
  input wire pair_cfg_t [NUM_PAIR-1:0] pair_cfg_in,
  // Gate commands.
  output logic [NUM_HB-1:0] high_gate_cmd,
  output logic [NUM_HB-1:0] low_gate_cmd,
  // Status.
  output bridge_mode_t active_mode,
  output pair_state_t [NUM_PAIR-1:0] pair_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers

  bridge_mode_t mode_r;
  hb_cfg_t [NUM_HB-1:0] hb_cfg_r;
  pair_cfg_t [NUM_PAIR-1:0] pair_cfg_r;

  // Captures the settings on a write; the freewheel side resets to low side.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_r <= MODE_RESET;
      hb_cfg_r <= {NUM_HB{HB_CFG_RESET}};
      pair_cfg_r <= {NUM_PAIR{PAIR_CFG_RESET}};
    end else if (config_write) begin
      mode_r <= bridge_mode_t'(bridge_config_sel);
      hb_cfg_r <= hb_cfg_in;
      pair_cfg_r <= pair_cfg_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective settings

  logic [3:0] ctrl_in;
  bridge_mode_t mode_eff;
  hb_cfg_t [NUM_HB-1:0] hb_cfg_eff;
  pair_cfg_t [NUM_PAIR-1:0] pair_cfg_eff;

  // Gathers the control inputs in input order one to four.
  assign ctrl_in = {pair2_direction_input, pair2_enable_input,
                    pair1_direction_input, pair1_enable_input};

  // Picks the mode from the selector register or from the mode pin.
  always_comb begin
    mode_eff = mode_r;
    if (!HAS_REG_PORT) begin
      case (mode_pin_level)
        PIN_LEVEL_1: mode_eff = MODE_HALF;
        PIN_LEVEL_2: mode_eff = MODE_SPEED_DIR;
        PIN_LEVEL_3: mode_eff = MODE_FOUR_STATE;
        PIN_LEVEL_4: mode_eff = MODE_SOLENOID;
        default: mode_eff = MODE_HALF;
      endcase
    end
  end

  // Without the register port every bridge takes fixed settings.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_HB; gi++) begin : g_hb_cfg
      always_comb begin
        hb_cfg_eff[gi] = hb_cfg_r[gi];
        if (!HAS_REG_PORT) begin
          hb_cfg_eff[gi].state_sel = HB_PWM;
          hb_cfg_eff[gi].input_sel = 2'(gi);
          hb_cfg_eff[gi].active_side = SIDE_HIGH;
          hb_cfg_eff[gi].freewheel_kind = FW_ACTIVE;
        end
      end
    end
  endgenerate

  // Without the register port the pairs use pins and low-side freewheel.
  generate
    for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair_cfg
      always_comb begin
        pair_cfg_eff[gi] = pair_cfg_r[gi];
        if (!HAS_REG_PORT) begin
          pair_cfg_eff[gi] = PAIR_CFG_RESET;
          pair_cfg_eff[gi].freewheel_side = FW_SIDE_LOW;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Half-bridge mode patterns

  gate_t [NUM_HB-1:0] hb_gate;

  // One mapper per half-bridge.
  generate
    for (gi = 0; gi < NUM_HB; gi++) begin : g_hb_map
      half_bridge_map u_map (
        .cfg(hb_cfg_eff[gi]),
        .ctrl_in(ctrl_in),
        .gate(hb_gate[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // H-bridge and solenoid patterns per pair

  gate_t [NUM_HB-1:0] pair_gate;
  pair_state_t [NUM_PAIR-1:0] pair_state_nxt;

  // Pairs are bridges 2p and 2p+1; 1/2 and 3/4 counting from one.
  generate
    for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair
      logic en;
      logic dir;
      logic fw_high;

      // Enable and direction come from the pins or from register bits.
      assign en = (pair_cfg_eff[gi].enable_source_sel == SRC_REG) ?
                  pair_cfg_eff[gi].solenoid_pwm_bit : ctrl_in[2*gi];
      assign dir = (pair_cfg_eff[gi].direction_source_sel == SRC_REG) ?
                   pair_cfg_eff[gi].solenoid_disconnect_bit : ctrl_in[2*gi+1];
      assign fw_high = (pair_cfg_eff[gi].freewheel_side == FW_SIDE_HIGH);

      // Builds the gate pattern of the pair for the active mode.
      always_comb begin
        pair_gate[2*gi] = GATE_OFF;
        pair_gate[2*gi+1] = GATE_OFF;
        pair_state_nxt[gi] = PS_HALF;
        case (mode_eff)
          MODE_SPEED_DIR: begin
            if (!en) begin
              // Direction has no effect while the enable is low.
              pair_gate[2*gi] = '{fw_high, !fw_high};
              pair_gate[2*gi+1] = '{fw_high, !fw_high};
              pair_state_nxt[gi] = fw_high ? PS_FW_HIGH : PS_FW_LOW;
            end else if (dir) begin
              pair_gate[2*gi] = '{1'b1, 1'b0};
              pair_gate[2*gi+1] = '{1'b0, 1'b1};
              pair_state_nxt[gi] = PS_FORWARD;
            end else begin
              pair_gate[2*gi] = '{1'b0, 1'b1};
              pair_gate[2*gi+1] = '{1'b1, 1'b0};
              pair_state_nxt[gi] = PS_REVERSE;
            end
          end
          MODE_FOUR_STATE: begin
            case ({en, dir})
              2'b00: begin
                pair_state_nxt[gi] = PS_COAST;
              end
              2'b10: begin
                pair_gate[2*gi] = '{1'b1, 1'b0};
                pair_gate[2*gi+1] = '{1'b0, 1'b1};
                pair_state_nxt[gi] = PS_FORWARD;
              end
              2'b01: begin
                pair_gate[2*gi] = '{1'b0, 1'b1};
                pair_gate[2*gi+1] = '{1'b1, 1'b0};
                pair_state_nxt[gi] = PS_REVERSE;
              end
              2'b11: begin
                pair_gate[2*gi] = '{fw_high, !fw_high};
                pair_gate[2*gi+1] = '{fw_high, !fw_high};
                pair_state_nxt[gi] = fw_high ? PS_FW_HIGH : PS_FW_LOW;
              end
              default: begin
                pair_state_nxt[gi] = PS_COAST;
              end
            endcase
          end
          MODE_SOLENOID: begin
            // Primary high side is the disconnect switch, secondary low side the PWM switch.
            pair_gate[2*gi] = '{dir, 1'b0};
            pair_gate[2*gi+1] = '{1'b0, en};
            pair_state_nxt[gi] = PS_SOLENOID;
          end
          default: begin
            pair_state_nxt[gi] = PS_HALF;
          end
        endcase
        // The float bit overrides inputs and freewheel settings.
        if (mode_eff != MODE_HALF && pair_cfg_eff[gi].float_en) begin
          pair_gate[2*gi] = GATE_OFF;
          pair_gate[2*gi+1] = GATE_OFF;
          pair_state_nxt[gi] = PS_FLOAT;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output selection and registers

  logic [NUM_HB-1:0] high_gate_nxt;
  logic [NUM_HB-1:0] low_gate_nxt;

  // Half-bridge mode takes the mappers, every other mode the pair logic.
  generate
    for (gi = 0; gi < NUM_HB; gi++) begin : g_sel
      always_comb begin
        if (mode_eff == MODE_HALF) begin
          high_gate_nxt[gi] = hb_gate[gi].high;
          low_gate_nxt[gi] = hb_gate[gi].low;
        end else begin
          high_gate_nxt[gi] = pair_gate[gi].high;
          low_gate_nxt[gi] = pair_gate[gi].low;
        end
      end
    end
  endgenerate

  // Registers the gate commands; reset floats every half-bridge.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_gate_cmd <= '0;
      low_gate_cmd <= '0;
    end else begin
      high_gate_cmd <= high_gate_nxt;
      low_gate_cmd <= low_gate_nxt;
    end
  end

  // Registers the status seen by software.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_mode <= MODE_RESET;
      pair_state <= '{default: PS_HALF};
    end else begin
      active_mode <= mode_eff;
      pair_state <= pair_state_nxt;
    end
  end

endmodule

// [hw/gate_pkg.sv]
// Shared types and constants for the half-bridge gate control logic.
package gate_pkg;

  // Number of half-bridges and of H-bridge pairs.
  localparam int NUM_HB = 4;
  localparam int NUM_PAIR = 2;

  // Bridge operating modes, also the encoding of the mode selector.
  typedef enum logic [1:0] {
    MODE_HALF       = 2'b00,
    MODE_SPEED_DIR  = 2'b01,
    MODE_FOUR_STATE = 2'b10,
    MODE_SOLENOID   = 2'b11
  } bridge_mode_t;

  // Per half-bridge state selector encodings.
  typedef enum logic [1:0] {
    HB_FLOAT = 2'b00,
    HB_LOW   = 2'b01,
    HB_HIGH  = 2'b10,
    HB_PWM   = 2'b11
  } hb_state_t;

  // Pair status as reported on the status port.
  typedef enum logic [2:0] {
    PS_HALF      = 3'b000,
    PS_FLOAT     = 3'b001,
    PS_COAST     = 3'b010,
    PS_FORWARD   = 3'b011,
    PS_REVERSE   = 3'b100,
    PS_FW_LOW    = 3'b101,
    PS_FW_HIGH   = 3'b110,
    PS_SOLENOID  = 3'b111
  } pair_state_t;

  // Field values of the single-bit settings.
  localparam logic SIDE_HIGH = 1'b0;
  localparam logic SIDE_LOW = 1'b1;
  localparam logic FW_ACTIVE = 1'b0;
  localparam logic FW_PASSIVE = 1'b1;
  localparam logic FW_SIDE_LOW = 1'b0;
  localparam logic FW_SIDE_HIGH = 1'b1;
  localparam logic SRC_PIN = 1'b0;
  localparam logic SRC_REG = 1'b1;

  // Multi-level mode pin, level 1 to level 4.
  localparam logic [1:0] PIN_LEVEL_1 = 2'h0;
  localparam logic [1:0] PIN_LEVEL_2 = 2'h1;
  localparam logic [1:0] PIN_LEVEL_3 = 2'h2;
  localparam logic [1:0] PIN_LEVEL_4 = 2'h3;

  // Settings of one half-bridge.
  typedef struct packed {
    hb_state_t state_sel;
    logic [1:0] input_sel;
    logic active_side;
    logic freewheel_kind;
  } hb_cfg_t;

  // Settings of one H-bridge pair.
  typedef struct packed {
    logic freewheel_side;
    logic float_en;
    logic enable_source_sel;
    logic direction_source_sel;
    logic solenoid_pwm_bit;
    logic solenoid_disconnect_bit;
  } pair_cfg_t;

  // Gate command of one half-bridge.
  typedef struct packed {
    logic high;
    logic low;
  } gate_t;

  // Reset values of the settings and of the gates.
  localparam bridge_mode_t MODE_RESET = MODE_HALF;
  localparam hb_cfg_t HB_CFG_RESET = '{HB_FLOAT, 2'h0, SIDE_HIGH, FW_ACTIVE};
  localparam pair_cfg_t PAIR_CFG_RESET = '{FW_SIDE_LOW, 1'b0, SRC_PIN, SRC_PIN, 1'b0, 1'b0};
  localparam gate_t GATE_OFF = '{1'b0, 1'b0};

endpackage

// [hw/half_bridge_map.sv]
// Gate pattern of one half-bridge in half-bridge mode.
`timescale 1ns/10ps
module half_bridge_map
  import gate_pkg::*;
(
  // Settings of this half-bridge.
  input wire hb_cfg_t cfg,
  // The four control inputs.
  input wire logic [3:0] ctrl_in,
  // Resulting gate command.
  output gate_t gate
);

  logic pwm;

  // Picks the mapped input; any input may feed any half-bridge.
  assign pwm = ctrl_in[cfg.input_sel];

  // Turns the state selector and the PWM settings into a gate pattern.
  always_comb begin
    gate = GATE_OFF;
    case (cfg.state_sel)
      HB_FLOAT: begin
        gate = GATE_OFF;
      end
      HB_LOW: begin
        gate.low = 1'b1;
      end
      HB_HIGH: begin
        gate.high = 1'b1;
      end
      HB_PWM: begin
        if (cfg.active_side == SIDE_HIGH) begin
          gate.high = pwm;
          gate.low = (cfg.freewheel_kind == FW_ACTIVE) ? ~pwm : 1'b0;
        end else begin
          gate.low = pwm;
          gate.high = (cfg.freewheel_kind == FW_ACTIVE) ? ~pwm : 1'b0;
        end
      end
      default: begin
        gate = GATE_OFF;
      end
    endcase
  end

endmodule

// [tb/bridge_gate_control_assertions.sv]
// Port checks for the bridge gate control logic.
`timescale 1ns/10ps
module bridge_gate_control_assertions
  import gate_pkg::*;
#(
  parameter bit HAS_REG_PORT = 1'b1
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control inputs and settings.
  input wire logic pair1_enable_input,
  input wire logic pair1_direction_input,
  input wire logic config_write,
  input wire logic [1:0] bridge_config_sel,
  input wire pair_cfg_t [NUM_PAIR-1:0] pair_cfg_in,
  // Gate commands and status.
  input wire logic [NUM_HB-1:0] high_gate_cmd,
  input wire logic [NUM_HB-1:0] low_gate_cmd,
  input wire bridge_mode_t active_mode,
  input wire pair_state_t [NUM_PAIR-1:0] pair_state
);
  logic [1:0] mode_r;
  pair_cfg_t [NUM_PAIR-1:0] pc_r;

  // Mirror of the settings latched on each write.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_r <= MODE_RESET;
      pc_r <= {NUM_PAIR{PAIR_CFG_RESET}};
    end else if (config_write) begin
      mode_r <= bridge_config_sel;
      pc_r <= pair_cfg_in;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Pair one in the given mode, not floating, with both values taken from the pins.
  sequence s_live(logic [1:0] m);
    HAS_REG_PORT && mode_r == m && pc_r[0][4:2] == 3'b000;
  endsequence

  a_reset_clears: assert property (disable iff (1'b0) !reset_n |=> {high_gate_cmd, low_gate_cmd} == 8'h00)
    else $error("gates not cleared by reset");
  a_gates_exclusive: assert property ((high_gate_cmd & low_gate_cmd) == 4'h0)
    else $error("both gates of one half-bridge on");
  a_mode_follows: assert property (HAS_REG_PORT |-> active_mode == $past(mode_r))
    else $error("active mode does not follow the written selector");
  a_pair_float: assert property (HAS_REG_PORT && mode_r != MODE_HALF && pc_r[1].float_en
    |=> {high_gate_cmd[3:2], low_gate_cmd[3:2]} == 4'h0) else $error("floating pair drives a gate");
  a_speed_forward: assert property (s_live(MODE_SPEED_DIR) ##0 (pair1_enable_input && pair1_direction_input)
    |=> high_gate_cmd[1:0] == 2'b01 && low_gate_cmd[1:0] == 2'b10 && pair_state[0] == PS_FORWARD)
    else $error("forward drive pattern wrong");
  a_four_coast: assert property (s_live(MODE_FOUR_STATE) ##0 (!pair1_enable_input && !pair1_direction_input)
    |=> {high_gate_cmd[1:0], low_gate_cmd[1:0]} == 4'h0 && pair_state[0] == PS_COAST)
    else $error("coast pattern wrong");
  a_solenoid_idle: assert property (HAS_REG_PORT && mode_r == MODE_SOLENOID
    |=> (low_gate_cmd & 4'h5) == 4'h0 && (high_gate_cmd & 4'ha) == 4'h0) else $error("disabled solenoid gate on");
  a_solenoid_follow: assert property (s_live(MODE_SOLENOID)
    |=> high_gate_cmd[0] == $past(pair1_direction_input) && low_gate_cmd[1] == $past(pair1_enable_input))
    else $error("solenoid gates do not follow the inputs");
endmodule

bind bridge_gate_control_logic bridge_gate_control_assertions #(.HAS_REG_PORT(HAS_REG_PORT)) i_checker (
  .clk(clk), .reset_n(reset_n), .pair1_enable_input(pair1_enable_input),
  .pair1_direction_input(pair1_direction_input), .config_write(config_write),
  .bridge_config_sel(bridge_config_sel), .pair_cfg_in(pair_cfg_in), .high_gate_cmd(high_gate_cmd),
  .low_gate_cmd(low_gate_cmd), .active_mode(active_mode), .pair_state(pair_state));

// [tb/ctrl_mcu_model.sv]
// Controller model that drives the four control inputs.
`timescale 1ns/10ps
module ctrl_mcu_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Wanted levels and whether speed/direction drive is in use.
  input wire logic [3:0] want,
  input wire logic speed_dir,
  // Control input pins.
  output logic [3:0] pins
);
  logic [2:0] hold_r = 3'h0;

  // Pins change just after each edge; direction stays put for eight cycles in speed/direction drive.
  initial pins = 4'h0;
  always @(posedge clk) begin
    hold_r <= reset_n ? hold_r + 3'h1 : 3'h0;
    pins[0] <= #1 want[0];
    pins[2] <= #1 want[2];
    if (!speed_dir || hold_r == 3'h0) begin
      pins[1] <= #1 want[1];
      pins[3] <= #1 want[3];
    end
  end
endmodule

// [tb/tb_bridge_gate_control_logic.sv]
// Self-checking bench for the bridge gate control logic.
`timescale 1ns/10ps
module tb_bridge_gate_control_logic
  import gate_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic config_write = 1'b0;
  logic chk_en = 1'b0;
  bridge_mode_t mode_sel = MODE_HALF;
  hb_cfg_t [NUM_HB-1:0] hb_cfg = '0;
  hb_cfg_t [NUM_HB-1:0] hb_fix;
  pair_cfg_t [NUM_PAIR-1:0] pair_cfg = '0;
  logic [3:0] want = 4'h0;
  logic [3:0] pins;
  logic [3:0] high_gate_cmd;
  logic [3:0] low_gate_cmd;
  logic [3:0] pin_high;
  logic [3:0] pin_low;
  bridge_mode_t active_mode;
  pair_state_t [NUM_PAIR-1:0] pair_state;
  logic [31:0] lfsr_r = 32'he017_3d5f;
  logic [7:0] exp_r = 8'h00;
  logic [7:0] exp_pin_r = 8'h00;
  logic [5:0] exp_ps_r = 6'h00;
  bridge_mode_t pin_mode;
  int num_errors = 0;
  int samples_checked = 0;

  // Clock of 4 ns.
  initial begin
    forever #2 clk = ~clk;
  end

  ctrl_mcu_model i_mcu (.clk(clk), .reset_n(reset_n), .want(want), .speed_dir(mode_sel == MODE_SPEED_DIR),
    .pins(pins));
  bridge_gate_control_logic #(.HAS_REG_PORT(1'b1)) i_dut (.clk(clk), .reset_n(reset_n),
    .pair1_enable_input(pins[0]), .pair1_direction_input(pins[1]), .pair2_enable_input(pins[2]),
    .pair2_direction_input(pins[3]), .mode_pin_level(lfsr_r[9:8]), .config_write(config_write),
    .bridge_config_sel(mode_sel), .hb_cfg_in(hb_cfg), .pair_cfg_in(pair_cfg), .high_gate_cmd(high_gate_cmd),
    .low_gate_cmd(low_gate_cmd), .active_mode(active_mode), .pair_state(pair_state));
  // Pin-configured variant: mode from the mode pin, settings writes must leave it unmoved.
  bridge_gate_control_logic #(.HAS_REG_PORT(1'b0)) i_pin (.clk(clk), .reset_n(reset_n),
    .pair1_enable_input(pins[0]), .pair1_direction_input(pins[1]), .pair2_enable_input(pins[2]),
    .pair2_direction_input(pins[3]), .mode_pin_level(mode_sel), .config_write(config_write),
    .bridge_config_sel(mode_sel), .hb_cfg_in(hb_cfg), .pair_cfg_in(pair_cfg), .high_gate_cmd(pin_high),
    .low_gate_cmd(pin_low), .active_mode(pin_mode), .pair_state());

  // Next value of the random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {high, low} gates for given settings and inputs.
  function automatic logic [7:0] gates_of(bridge_mode_t m, hb_cfg_t [3:0] hb, pair_cfg_t [1:0] pc, logic [3:0] in);
    logic [3:0] h;
    logic [3:0] l;
    logic p;
    logic en;
    logic dir;
    logic fwd;
    int a;
    h = 4'h0;
    l = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p = in[hb[i].input_sel];
      if (m == MODE_HALF && hb[i].state_sel == HB_LOW) l[i] = 1'b1;
      if (m == MODE_HALF && hb[i].state_sel == HB_HIGH) h[i] = 1'b1;
      if (m == MODE_HALF && hb[i].state_sel == HB_PWM) begin
        h[i] = (hb[i].active_side == SIDE_HIGH) ? p : (!hb[i].freewheel_kind && !p);
        l[i] = (hb[i].active_side == SIDE_LOW) ? p : (!hb[i].freewheel_kind && !p);
      end
    end
    for (int k = 0; k < 2; k++) begin
      a = 2 * k;
      en = pc[k].enable_source_sel ? pc[k].solenoid_pwm_bit : in[a];
      dir = pc[k].direction_source_sel ? pc[k].solenoid_disconnect_bit : in[a + 1];
      fwd = (m == MODE_SPEED_DIR) ? dir : en;
      if (m == MODE_HALF || pc[k].float_en) begin
      end else if (m == MODE_SOLENOID) begin
        h[a] = dir;
        l[a + 1] = en;
      end else if (m == MODE_SPEED_DIR ? en : (en ^ dir)) begin
        {h[a], l[a], h[a + 1], l[a + 1]} = {fwd, !fwd, !fwd, fwd};
      end else if (m == MODE_SPEED_DIR || en) begin
        {h[a], l[a], h[a + 1], l[a + 1]} = {4{pc[k].freewheel_side}} ^ 4'b0101;
      end
    end
    return {h, l};
  endfunction

  // Expected status of both pairs, pair one in the low three bits.
  function automatic logic [5:0] states_of(bridge_mode_t m, pair_cfg_t [1:0] pc, logic [3:0] in);
    logic [5:0] s;
    logic en;
    logic dir;
    pair_state_t ps;
    s = 6'h00;
    for (int k = 0; k < 2; k++) begin
      en = pc[k].enable_source_sel ? pc[k].solenoid_pwm_bit : in[2 * k];
      dir = pc[k].direction_source_sel ? pc[k].solenoid_disconnect_bit : in[2 * k + 1];
      if (m == MODE_HALF) begin
        ps = PS_HALF;
      end else if (pc[k].float_en) begin
        ps = PS_FLOAT;
      end else if (m == MODE_SOLENOID) begin
        ps = PS_SOLENOID;
      end else if (m == MODE_SPEED_DIR ? en : (en ^ dir)) begin
        ps = (m == MODE_SPEED_DIR ? dir : en) ? PS_FORWARD : PS_REVERSE;
      end else if (m == MODE_SPEED_DIR || en) begin
        ps = pc[k].freewheel_side ? PS_FW_HIGH : PS_FW_LOW;
      end else begin
        ps = PS_COAST;
      end
      s[3 * k +: 3] = ps;
    end
    return s;
  endfunction

  // Compares one value and reports a mismatch.
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      num_errors++;
      $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, expd);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checked %0d values, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Writes mode and settings for one cycle, pausing the comparisons meanwhile.
  task automatic cfg_write(input bridge_mode_t m, input logic [35:0] w);
    @(posedge clk);
    #1;
    chk_en = 1'b0;
    config_write = 1'b1;
    mode_sel = m;
    hb_cfg = w[23:0];
    pair_cfg = w[35:24];
    @(posedge clk);
    #1;
    config_write = 1'b0;
    @(posedge clk);
    #1;
    chk_en = 1'b1;
  endtask

  // Random control inputs for a number of cycles.
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      lfsr_r = lfsr(lfsr_r);
      want = lfsr_r[3:0];
    end
  endtask

  // Scoreboard: outputs seen now against inputs and settings of the previous edge.
  always @(posedge clk) begin
    if (chk_en) begin
      check({high_gate_cmd, low_gate_cmd}, exp_r);
      check({pin_high, pin_low}, exp_pin_r);
      check({6'h00, active_mode}, {6'h00, mode_sel});
      check({6'h00, pin_mode}, {6'h00, mode_sel});
      check({2'h0, pair_state}, {2'h0, exp_ps_r});
    end
    exp_r = reset_n ? gates_of(mode_sel, hb_cfg, pair_cfg, pins) : 8'h00;
    exp_pin_r = reset_n ? gates_of(mode_sel, hb_fix, {2{PAIR_CFG_RESET}}, pins) : 8'h00;
    exp_ps_r = reset_n ? states_of(mode_sel, pair_cfg, pins) : 6'h00;
  end

  // Main sequence: reset, a shared-input corner, then random settings in every mode.
  initial begin
    for (int i = 0; i < 4; i++) hb_fix[i] = '{HB_PWM, 2'(i), SIDE_HIGH, FW_ACTIVE};
    repeat (20) @(posedge clk);
    #1;
    check({high_gate_cmd, low_gate_cmd}, 8'h00);
    check({2'h0, pair_state}, 8'h00);
    reset_n = 1'b1;
    chk_en = 1'b1;
    run(8);
    cfg_write(MODE_HALF, 36'h0_00ef_9eb8);
    run(40);
    for (int n = 0; n < 40; n++) begin
      if (n == 20) begin
        // A reset in mid-run must drop every half-bridge back to float in half-bridge mode.
        @(posedge clk);
        #1;
        chk_en = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) begin
          @(posedge clk);
          #1;
          check({high_gate_cmd, low_gate_cmd}, 8'h00);
          check({2'h0, pair_state}, 8'h00);
          check({6'h00, active_mode}, {6'h00, MODE_RESET});
        end
      end
      lfsr_r = lfsr(lfsr_r);
      cfg_write(bridge_mode_t'(n[1:0]), (n < 8) ? {12'h000, lfsr_r[23:0]} : {lfsr_r[31:20], lfsr_r[23:0]});
      run(40);
    end
    test_done();
  end

  // Watchdog against a hang.
  initial begin
    #40000;
    num_errors++;
    test_done();
  end
endmodule
